// ### iodp_defs.svh
// Constants of the device-controller channel port
// Summary of operation
// - Data path is 8, 16 or 32 bits, one, two or four lanes.
// - Each processor owns one independent path; this port serves one path.
// - Chained controllers take turns on the path, never driving together.
// - A one-lane controller works with every processor variant.
// - Every busy controller may raise its service request at once.
// - On a selector processor only one controller is busy at a time.
// - Priority chain picks highest requester; it returns address with acknowledge.
// - A connected controller asks for exactly one of four operations.
// - One connection moves up to four data bytes (no byte limit on a selector) or one control byte.
// - Data lanes are two-way; only one side drives at a time.
// - Interrupt acknowledge returns controller status on first lane only.
// - Status-to-processor returns one status byte on first lane only.
// - Data transfers use every lane of the configured path.
// - Addressed controller acknowledges the strobe; others pass the grant on.
// - Pending requester acknowledges only with grant and with no claim on the line, unless it drives its own claim.
// - Request strobe and its acknowledge form a closed loop.
`ifndef IODP_DEFS_SVH
`define IODP_DEFS_SVH
`define IODP_OP_DATA_OUT 2'h0
`define IODP_OP_DATA_IN 2'h1
`define IODP_OP_ORDER_OUT 2'h2
`define IODP_OP_STATUS_IN 2'h3
`define IODP_MAX_CONN_BYTES 3'h4
`define IODP_BYTE_RST 8'h00
`define IODP_WORD_RST 32'h0000_0000
`define IODP_LANES_RST 4'h0
`define IODP_FIRST_LANE 4'h1
`endif

// ### iodp_pkg.sv
// Types of the device-controller channel port
package iodp_pkg;
  typedef enum logic [2:0] {
    IODP_IDLE = 3'h0,
    IODP_ACK = 3'h1,
    IODP_CONN = 3'h3,
    IODP_STROBE = 3'h2,
    IODP_RELEASE = 3'h6
  } iodp_state_e;
  typedef logic [1:0] iodp_op_t;
endpackage : iodp_pkg

// ### iodp_lane_steer.sv
// Byte-lane driver and receive mask for the shared data lanes
`timescale 1ns/1ps
`default_nettype none
`include "iodp_defs.svh"
module iodp_lane_steer
  import iodp_pkg::*;
#(
  parameter int LANES = 4
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic release_,
  input wire logic firstOnly,
  input wire logic [31:0] txData,
  input wire logic [31:0] rxRaw,
  output logic [31:0] laneOut,
  output logic [3:0] laneOe,
  output logic [31:0] rxData
);
  function automatic logic [3:0] laneMask(input logic first);
    logic [3:0] m;
    m = (LANES == 4) ? 4'hF : (LANES == 2) ? 4'h3 : 4'h1;
    laneMask = first ? `IODP_FIRST_LANE : m;
  endfunction : laneMask

  // One, two or four lanes are the only widths with wiring behind them
  if (LANES != 1 && LANES != 2 && LANES != 4)
  begin : g_bad_lanes
    $error("LANES must be 1, 2 or 4");
  end

  logic [3:0] rxMask;
  assign rxMask = laneMask(firstOnly);

  // Only lanes of the active width pass or drive data
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      logic [7:0] byteQ;
      logic oeQ;
      assign rxData[8*g +: 8] = rxMask[g] ? rxRaw[8*g +: 8] : `IODP_BYTE_RST;
      assign laneOut[8*g +: 8] = byteQ;
      assign laneOe[g] = oeQ;
      always_ff @(posedge clock)
      begin
        if (sys_rst || release_)
        begin
          byteQ <= `IODP_BYTE_RST;
          oeQ <= 1'b0;
        end
        else if (load)
        begin
          byteQ <= rxMask[g] ? txData[8*g +: 8] : `IODP_BYTE_RST;
          oeQ <= rxMask[g];
        end
      end
    end
  endgenerate
endmodule : iodp_lane_steer
`default_nettype wire

// ### iodp_device_port.sv
// Device-controller end of the shared processor channel
`timescale 1ns/1ps
`default_nettype none
`include "iodp_defs.svh"
module iodp_device_port
  import iodp_pkg::*;
#(
  parameter int LANES = 4,
  parameter logic [7:0] DEV_ADDR = 8'h01,
  parameter bit SELECTOR = 1'b0,
  parameter bit HIGH_PRIORITY = 1'b0
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic startInstr,
  input wire logic haltInstr,
  input wire logic testInstr,
  input wire logic deviceTestInstr,
  input wire logic interruptAckInstr,
  input wire logic serviceAckIndicator,
  input wire logic functionStrobe,
  input wire logic chainGrantIn,
  input wire logic highPriorityClaimIn,
  input wire logic requestStrobeAck,
  input wire logic endService,
  input wire logic [31:0] laneIn,
  output logic [31:0] laneOut,
  output logic [3:0] laneOe,
  output logic strobeAck,
  output logic chainGrantOut,
  output logic serviceRequest,
  output logic highPriorityClaimOut,
  output logic highPriorityClaimOe,
  output logic requestStrobe,
  output logic [7:0] responseOut,
  output logic responseOe,
  output logic dataOrder,
  output logic ioRequest,
  input wire logic userSvcReq,
  input wire logic [1:0] userOp,
  input wire logic userIntPending,
  input wire logic [7:0] userIntStatus,
  input wire logic [7:0] userDevStatus,
  input wire logic [31:0] userTxData,
  output logic userTxTake,
  output logic [31:0] userRxData,
  output logic userRxValid,
  output logic userIntAck,
  output logic userSvcDone,
  output logic connected
);
  // Wider lane counts are not wired on any channel variant
  if (LANES != 1 && LANES != 2 && LANES != 4)
  begin : g_bad_lanes
    $error("LANES must be 1, 2 or 4");
  end

  iodp_state_e stateQ;
  iodp_op_t opQ;
  logic svcPendQ, ackAioQ, ackAscQ, endSeenQ;
  logic [2:0] byteCntQ;
  logic [31:0] rxData;
  logic addrInstr, addrHit, claimOk, respond, isOrder, connDone;
  logic laneLoad, laneRelease, laneFirst;
  logic [2:0] stepBytes;

  assign addrInstr = startInstr | haltInstr | testInstr | deviceTestInstr;
  assign addrHit = laneIn[7:0] == DEV_ADDR;
  assign claimOk = !highPriorityClaimIn || highPriorityClaimOe;
  assign respond = functionStrobe && chainGrantIn &&
    ((addrInstr && addrHit) || (interruptAckInstr && userIntPending) ||
     (serviceAckIndicator && svcPendQ && claimOk));
  assign isOrder = opQ == `IODP_OP_ORDER_OUT || opQ == `IODP_OP_STATUS_IN;
  assign stepBytes = isOrder ? 3'h1 : 3'(LANES);
  assign connDone = endSeenQ ||
    (isOrder ? byteCntQ != 3'h0 :
     (!SELECTOR && byteCntQ >= `IODP_MAX_CONN_BYTES));

  // Sequence of acknowledge, connection and strobed transfers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stateQ <= IODP_IDLE;
    else
    begin
      unique case (stateQ)
        IODP_IDLE:
          if (respond && !chainGrantOut)
            stateQ <= IODP_ACK;
        IODP_ACK:
          if (!functionStrobe)
            stateQ <= ackAscQ ? IODP_CONN : IODP_IDLE;
        IODP_CONN:
          stateQ <= connDone ? IODP_IDLE : IODP_STROBE;
        IODP_STROBE:
          if (requestStrobeAck)
            stateQ <= IODP_RELEASE;
        IODP_RELEASE:
          if (!requestStrobeAck)
            stateQ <= IODP_CONN;
      endcase
    end
  end

  // Pending service: a new request wins over the end of a connection
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      svcPendQ <= 1'b0;
      opQ <= `IODP_OP_DATA_OUT;
    end
    else if (userSvcReq && !svcPendQ)
    begin
      svcPendQ <= 1'b1;
      opQ <= userOp;
    end
    else if (stateQ == IODP_CONN && connDone && !userSvcReq)
      svcPendQ <= 1'b0;
  end

  // Strobe answer and grant passing toward the next controller
  always_ff @(posedge clock)
  begin
    if (sys_rst || !functionStrobe)
    begin
      strobeAck <= 1'b0;
      chainGrantOut <= 1'b0;
      ackAioQ <= 1'b0;
      ackAscQ <= 1'b0;
      responseOe <= 1'b0;
      responseOut <= `IODP_BYTE_RST;
      dataOrder <= 1'b0;
      ioRequest <= 1'b0;
    end
    // Once the grant went downstream this strobe belongs to another unit
    else if (stateQ == IODP_IDLE && respond && !chainGrantOut)
    begin
      strobeAck <= 1'b1;
      ackAioQ <= interruptAckInstr;
      ackAscQ <= serviceAckIndicator;
      responseOe <= 1'b1;
      responseOut <= addrInstr ? userDevStatus : DEV_ADDR;
      dataOrder <= serviceAckIndicator ? opQ[1] : 1'b0;
      ioRequest <= serviceAckIndicator ? opQ[0] : 1'b0;
    end
    else if (stateQ == IODP_IDLE && chainGrantIn && !strobeAck)
      chainGrantOut <= 1'b1;
  end

  // Connection bookkeeping and request strobe
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      connected <= 1'b0;
      requestStrobe <= 1'b0;
      byteCntQ <= 3'h0;
      endSeenQ <= 1'b0;
    end
    else
    begin
      if (stateQ == IODP_ACK && !functionStrobe && ackAscQ)
      begin
        connected <= 1'b1;
        byteCntQ <= 3'h0;
        endSeenQ <= 1'b0;
      end
      else if (stateQ == IODP_CONN && connDone)
        connected <= 1'b0;
      if (stateQ == IODP_CONN && !connDone)
        requestStrobe <= 1'b1;
      else if (stateQ == IODP_STROBE && requestStrobeAck)
      begin
        requestStrobe <= 1'b0;
        byteCntQ <= byteCntQ + stepBytes;
        endSeenQ <= endService;
      end
    end
  end

  // One-cycle notices toward the device side; service request and priority claim toward the channel
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      userTxTake <= 1'b0;
      userRxValid <= 1'b0;
      userRxData <= `IODP_WORD_RST;
      userIntAck <= 1'b0;
      userSvcDone <= 1'b0;
      serviceRequest <= 1'b0;
      highPriorityClaimOe <= 1'b0;
      highPriorityClaimOut <= 1'b0;
    end
    else
    begin
      userTxTake <= stateQ == IODP_STROBE && requestStrobeAck &&
        (opQ == `IODP_OP_DATA_IN || opQ == `IODP_OP_STATUS_IN);
      userRxValid <= stateQ == IODP_STROBE && requestStrobeAck &&
        (opQ == `IODP_OP_DATA_OUT || opQ == `IODP_OP_ORDER_OUT);
      if (stateQ == IODP_STROBE && requestStrobeAck)
        userRxData <= rxData;
      userIntAck <= stateQ == IODP_ACK && !functionStrobe && ackAioQ;
      userSvcDone <= stateQ == IODP_CONN && connDone;
      serviceRequest <= svcPendQ && !connected;
      highPriorityClaimOe <= HIGH_PRIORITY && svcPendQ && !connected;
      highPriorityClaimOut <= HIGH_PRIORITY && svcPendQ && !connected;
    end
  end

  // Lanes are driven only by the connected or acknowledging controller
  assign laneFirst = ackAioQ || isOrder;
  assign laneLoad = (stateQ == IODP_ACK && ackAioQ) ||
    (stateQ == IODP_CONN && !connDone &&
     (opQ == `IODP_OP_DATA_IN || opQ == `IODP_OP_STATUS_IN));
  assign laneRelease = stateQ == IODP_IDLE || stateQ == IODP_RELEASE ||
    (stateQ == IODP_ACK && !functionStrobe);

  iodp_lane_steer #(.LANES(LANES)) u_lanes (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(laneLoad),
    .release_(laneRelease),
    .firstOnly(laneFirst),
    .txData(ackAioQ ? {24'h0, userIntStatus} :
            opQ == `IODP_OP_STATUS_IN ? {24'h0, userDevStatus} : userTxData),
    .rxRaw(laneIn),
    .laneOut(laneOut),
    .laneOe(laneOe),
    .rxData(rxData)
  );

  localparam logic [3:0] USED = (LANES == 4) ? 4'hF :
    (LANES == 2) ? 4'h3 : 4'h1;

  property p_unused_lanes;
    @(posedge clock) disable iff (sys_rst) (laneOe & ~USED) == 4'h0;
  endproperty
  a_unused_lanes: assert property (p_unused_lanes)
    else $error("unused lane driven");
  property p_idle_released;
    @(posedge clock) disable iff (sys_rst)
      (stateQ == IODP_IDLE) |=> (laneOe == 4'h0 && !requestStrobe);
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("idle controller drives lanes");
  property p_ack_xor_pass;
    @(posedge clock) disable iff (sys_rst) !(strobeAck && chainGrantOut);
  endproperty
  a_ack_xor_pass: assert property (p_ack_xor_pass)
    else $error("acknowledge and grant pass together");
  property p_ack_cause;
    @(posedge clock) disable iff (sys_rst)
      $rose(strobeAck) |-> $past(chainGrantIn) && $past(functionStrobe);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without grant");
  property p_rs_loop;
    @(posedge clock) disable iff (sys_rst)
      requestStrobe && requestStrobeAck |=> !requestStrobe;
  endproperty
  a_rs_loop: assert property (p_rs_loop)
    else $error("strobe not dropped after acknowledge");
  property p_first_lane;
    @(posedge clock) disable iff (sys_rst)
      (laneOe != 4'h0 && (ackAioQ || opQ == `IODP_OP_STATUS_IN))
        |-> laneOe == `IODP_FIRST_LANE;
  endproperty
  a_first_lane: assert property (p_first_lane)
    else $error("status on more than the first lane");
  property p_conn_bytes;
    @(posedge clock) disable iff (sys_rst)
      connected && !SELECTOR |-> byteCntQ <= `IODP_MAX_CONN_BYTES;
  endproperty
  a_conn_bytes: assert property (p_conn_bytes)
    else $error("connection moved too many bytes");
  property p_op_stable;
    @(posedge clock) disable iff (sys_rst)
      connected && $past(connected) |-> $stable(opQ);
  endproperty
  a_op_stable: assert property (p_op_stable)
    else $error("operation changed while connected");
  property p_claim_pending;
    @(posedge clock) disable iff (sys_rst)
      highPriorityClaimOe |-> $past(svcPendQ);
  endproperty
  a_claim_pending: assert property (p_claim_pending)
    else $error("priority claim without request");
  property p_full_lanes;
    @(posedge clock) disable iff (sys_rst)
      $rose(requestStrobe) && opQ == `IODP_OP_DATA_IN |-> laneOe == USED;
  endproperty
  a_full_lanes: assert property (p_full_lanes)
    else $error("data-in not on all lanes");

  c_connect: cover property (@(posedge clock) $rose(connected));
  c_pass: cover property (@(posedge clock) $rose(chainGrantOut));
  c_int_ack: cover property (@(posedge clock) userIntAck);
  c_data: cover property (@(posedge clock) userRxValid);
endmodule : iodp_device_port
`default_nettype wire

// ### iodp_proc_model.sv
// Processor side of the channel: request strobe loop and lane resolution
`timescale 1ns/1ps
`default_nettype none
module iodp_proc_model
  import iodp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic esOn,
  input wire logic [3:0] procLanes,
  input wire logic [31:0] procData,
  input wire logic requestStrobe,
  input wire logic [31:0] laneOut,
  input wire logic [3:0] laneOe,
  output logic requestStrobeAck,
  output logic endService,
  output logic [31:0] laneIn
);
  logic [2:0] waitQ = 3'h0;
  logic fillQ = 1'b0;
  // Acknowledge after a delay, drop at once when the strobe falls
  always @(negedge clock)
  begin
    fillQ <= ~fillQ;
    if (sys_rst || !requestStrobe)
    begin
      waitQ <= 3'h0;
      requestStrobeAck <= 1'b0;
      endService <= 1'b0;
    end
    else if (!requestStrobeAck)
    begin
      waitQ <= waitQ + 3'h1;
      if (waitQ >= (slow ? 3'h4 : 3'h0))
      begin
        requestStrobeAck <= 1'b1;
        endService <= esOn;
      end
    end
  end
  // Released lanes show a changing pattern rather than the last value
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      if (procLanes[i])
        laneIn[8*i +: 8] = procData[8*i +: 8];
      else if (laneOe[i])
        laneIn[8*i +: 8] = laneOut[8*i +: 8];
      else
        laneIn[8*i +: 8] = fillQ ? 8'hA5 : 8'h5A;
  end
endmodule : iodp_proc_model
`default_nettype wire

// ### iodp_device_port_tb.sv
// Self-checking bench for the device-controller channel port
`timescale 1ns/1ps
`default_nettype none
`include "iodp_defs.svh"
`define CHK(nm, ex, gt) \
  begin \
    nCompared++; \
    if ((gt) !== (ex)) \
    begin \
      badCount++; \
      $display("unexpected %s: expected %0h seen %0h", nm, ex, gt); \
    end \
  end
`define WAITC(cond, nm) \
  begin \
    for (int k = 0; k < 20 && !(cond); k++) \
      @(negedge clock); \
    `CHK(nm, 1'b1, (cond)) \
  end
module iodp_device_port_tb
  import iodp_pkg::*;
;
  localparam logic [7:0] DEV = 8'h2C;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic [5:0] ind = 6'h00;
  logic fs = 1'b0, grant = 1'b1, hpcOther = 1'b0, svcReq = 1'b0;
  logic intPend = 1'b0, slow = 1'b0, esOn = 1'b0;
  iodp_op_t op = 2'h0;
  logic [7:0] intStat = 8'h96, devStat = 8'h4B;
  logic [31:0] txData = 32'hC3B2_A190, procData = 32'h0;
  logic [3:0] procLanes = 4'h0;
  logic [31:0] laneIn, laneOut, userRxData;
  logic [3:0] laneOe;
  logic [7:0] responseOut;
  logic strobeAck, chainGrantOut, serviceRequest, hpcOut, hpcOe;
  logic requestStrobe, rsAck, endSvc, responseOe, dataOrder, ioRequest;
  logic userTxTake, userRxValid, userIntAck, userSvcDone, connected;
  int badCount = 0, nCompared = 0, cycles = 0;

  iodp_device_port #(.LANES(4), .DEV_ADDR(DEV)) uut (
    .clock(clock), .sys_rst(sysRst),
    .startInstr(ind[0]), .haltInstr(ind[1]), .testInstr(ind[2]),
    .deviceTestInstr(ind[3]), .interruptAckInstr(ind[4]),
    .serviceAckIndicator(ind[5]), .functionStrobe(fs),
    .chainGrantIn(grant),
    .highPriorityClaimIn(hpcOther | (hpcOe & hpcOut)),
    .requestStrobeAck(rsAck), .endService(endSvc), .laneIn(laneIn),
    .laneOut(laneOut), .laneOe(laneOe), .strobeAck(strobeAck),
    .chainGrantOut(chainGrantOut), .serviceRequest(serviceRequest),
    .highPriorityClaimOut(hpcOut), .highPriorityClaimOe(hpcOe),
    .requestStrobe(requestStrobe), .responseOut(responseOut),
    .responseOe(responseOe), .dataOrder(dataOrder), .ioRequest(ioRequest),
    .userSvcReq(svcReq), .userOp(op), .userIntPending(intPend),
    .userIntStatus(intStat), .userDevStatus(devStat),
    .userTxData(txData), .userTxTake(userTxTake), .userRxData(userRxData),
    .userRxValid(userRxValid), .userIntAck(userIntAck),
    .userSvcDone(userSvcDone), .connected(connected));

  iodp_proc_model proc (
    .clock(clock), .sys_rst(sysRst), .slow(slow), .esOn(esOn),
    .procLanes(procLanes), .procData(procData),
    .requestStrobe(requestStrobe), .laneOut(laneOut), .laneOe(laneOe),
    .requestStrobeAck(rsAck), .endService(endSvc), .laneIn(laneIn));

  initial
  begin
    forever #20 clock = ~clock;
  end

  task automatic summarize;
    if (badCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      badCount++;
      summarize();
    end
  end

  // One indicator with the strobe; for the four addressed instructions the address goes on the first lane
  task automatic fsOp(input int idx, input logic [7:0] adr, input logic ack);
    @(negedge clock);
    ind = 6'h01 << idx;
    procLanes = (idx < 4) ? 4'h1 : 4'h0;
    procData = {24'h0, adr};
    fs = 1'b1;
    `WAITC(strobeAck | chainGrantOut, "answer")
    `CHK("strobeAck", ack, strobeAck);
    `CHK("chainGrantOut", ~ack, chainGrantOut);
    `CHK("responseOe", ack, responseOe);
  endtask : fsOp

  task automatic dropFs;
    @(negedge clock);
    fs = 1'b0;
    ind = 6'h00;
    procLanes = 4'h0;
    `WAITC(!strobeAck && !chainGrantOut, "released")
    `CHK("laneOe", 4'h0, laneOe);
    `CHK("responseOe", 1'b0, responseOe);
  endtask : dropFs

  task automatic addressed;
    for (int i = 0; i < 4; i++)
    begin
      fsOp(i, DEV, 1'b1);
      `CHK("addrStatus", devStat, responseOut);
      dropFs();
      fsOp(i, DEV + 8'h01, 1'b0);
      dropFs();
    end
    grant = 1'b0;
    @(negedge clock);
    ind = 6'h01;
    procLanes = 4'h1;
    procData = {24'h0, DEV};
    fs = 1'b1;
    repeat (4) @(negedge clock);
    `CHK("noGrantAck", 1'b0, strobeAck | chainGrantOut);
    dropFs();
    grant = 1'b1;
  endtask : addressed

  task automatic interruptAck;
    intPend = 1'b1;
    fsOp(4, 8'h00, 1'b1);
    // Status lane is loaded one cycle after the acknowledge
    @(negedge clock);
    `CHK("aioLaneOe", 4'h1, laneOe);
    `CHK("aioStatus", intStat, laneOut[7:0]);
    `CHK("aioAddr", DEV, responseOut);
    dropFs();
    `CHK("userIntAck", 1'b1, userIntAck);
    intPend = 1'b0;
    fsOp(4, 8'h00, 1'b0);
    dropFs();
    `CHK("noIntAck", 1'b0, userIntAck);
  endtask : interruptAck

  // Service call, connection and one transfer of the given operation
  task automatic svc(input iodp_op_t o, input logic [3:0] pl,
                     input logic es, input logic foreign);
    logic [3:0] expOe;
    expOe = (o == `IODP_OP_DATA_IN) ? 4'hF :
            (o == `IODP_OP_STATUS_IN) ? 4'h1 : 4'h0;
    @(negedge clock);
    op = o;
    svcReq = 1'b1;
    procData = 32'h8E7D_6C5B;
    esOn = es;
    @(negedge clock);
    svcReq = 1'b0;
    `WAITC(serviceRequest, "serviceRequest")
    `CHK("claimDrive", 1'b0, hpcOe | hpcOut);
    if (foreign)
    begin
      hpcOther = 1'b1;
      fsOp(5, 8'h00, 1'b0);
      dropFs();
      hpcOther = 1'b0;
    end
    fsOp(5, 8'h00, 1'b1);
    `CHK("ascAddr", DEV, responseOut);
    `CHK("opCode", o, {dataOrder, ioRequest});
    dropFs();
    `WAITC(connected, "connected")
    `WAITC(requestStrobe, "requestStrobe")
    procLanes = pl;
    `CHK("xferLaneOe", expOe, laneOe);
    if (o == `IODP_OP_DATA_IN)
      `CHK("dataIn", txData, laneOut);
    if (o == `IODP_OP_STATUS_IN)
      `CHK("statusIn", devStat, laneOut[7:0]);
    `WAITC(userRxValid | userTxTake, "transferDone")
    if (o == `IODP_OP_DATA_OUT)
      `CHK("dataOut", procData, userRxData);
    if (o == `IODP_OP_ORDER_OUT)
      `CHK("order", procData[7:0], userRxData[7:0]);
    `WAITC(!requestStrobe, "strobeLow")
    procLanes = 4'h0;
    `WAITC(userSvcDone, "svcDone")
    @(negedge clock);
    `CHK("connected", 1'b0, connected);
  endtask : svc

  initial
  begin
    repeat (16) @(negedge clock);
    `CHK("rstAck", 1'b0, strobeAck | serviceRequest | connected);
    `CHK("rstLaneOe", 4'h0, laneOe);
    sysRst = 1'b0;
    addressed();
    interruptAck();
    svc(`IODP_OP_DATA_OUT, 4'hF, 1'b0, 1'b0);
    slow = 1'b1;
    svc(`IODP_OP_DATA_IN, 4'h0, 1'b0, 1'b1);
    slow = 1'b0;
    svc(`IODP_OP_ORDER_OUT, 4'h1, 1'b0, 1'b0);
    svc(`IODP_OP_STATUS_IN, 4'h0, 1'b1, 1'b0);
    summarize();
  end
endmodule : iodp_device_port_tb
`default_nettype wire
